// file: design/dcs_defs.vh
// constants for the de-interleaved channel start block
// assumes: 4 channels, APB word registers, 125 MHz core clock
// Summary of operation
// - each serial bit clock runs at the core clock divided by twice the sum of divider value and one.
// - one sample takes at least 32 serial bit clocks to shift out of a channel.
// - after a start trigger each channel starts only when its own hold-off has elapsed.
// - the start trigger comes from the start pin or from a host register write.
// - in frame request mode the frame outputs of channels pulse at different times; frame end pulses of channels can coincide.
// - the serial clock divider is a five-bit field in bits 4 to 0 of mode register two.
// - a mode bit makes the frame output mark frame end when set, frame request when clear.
`ifndef DCS_DEFS_VH
`define DCS_DEFS_VH
`define DCS_NCH          4
`define DCS_OFS_CTRL     12'h000
`define DCS_OFS_STATUS   12'h004
`define DCS_OFS_MODE2    12'h010
`define DCS_OFS_SETUP    12'h014
`define DCS_OFS_HOLDOFF  12'h020
`define DCS_OFS_PHASE    12'h030
`define DCS_OFS_SAMPLE   12'h040
`define DCS_DIV_LSB      0
`define DCS_DIV_W        5
`define DCS_FEND_BIT     5
`define DCS_HOLD_W       16
`define DCS_PHASE_W      16
`define DCS_WORD_BITS    32
`define DCS_FIFO_DEPTH   4
`define DCS_FIFO_AW      2
`define DCS_RST_DIV      5'h00
`define DCS_RST_HOLD     16'h0000
`endif

// file: design/dcs_fifo.v
// small synchronous fifo with valid/ready on both sides
// assumes: single clock, clock enable freezes state
`timescale 1ns/1ps
module dcs_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             rst,
  input  wire             clk_en,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  reg             ovalid_q;
  wire            full   = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire            empty  = (wr_q == rd_q);
  wire            load   = !empty && (!ovalid_q || out_ready);
  wire            push   = in_valid && !full;
  assign in_ready  = !full;
  assign out_valid = ovalid_q;
  always @(posedge core_clk) begin
    if (clk_en && push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_q     <= {(AW+1){1'b0}};
      rd_q     <= {(AW+1){1'b0}};
      ovalid_q <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (load) begin
        out_data <= mem[rd_q[AW-1:0]];
        rd_q     <= rd_q + 1'b1;
        ovalid_q <= 1'b1;
      end else if (out_ready) begin
        ovalid_q <= 1'b0;
      end
    end
  end
endmodule // dcs_fifo

// file: design/dcs_top.v
// four channel start sequencer with staggered hold-off and serial frame/data shifters
// assumes: apb master on core_clk, start pin synchronous to core_clk
`timescale 1ns/1ps
`include "dcs_defs.vh"
module dcs_top (
  // clock, reset, enable
  input  wire        core_clk,
  input  wire        rst,
  input  wire        clk_en,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // start trigger pin
  input  wire        start_pin,
  // per-channel serial ports
  output reg  [3:0]  serial_clk,
  output reg  [3:0]  frame_output_pin,
  output reg  [3:0]  serial_data,
  output reg  [3:0]  chan_running
);
  localparam ST_IDLE = 3'b001;
  localparam ST_HOLD = 3'b010;
  localparam ST_RUN  = 3'b100;

  reg  [`DCS_DIV_W-1:0]  div_q;
  reg                    fend_q;
  reg  [15:0]            hold_cfg_q [0:3];
  reg  [15:0]            phase_q [0:3];
  reg                    soft_start_q;
  reg                    pin_q;
  wire                   acc    = psel && penable && !pready;
  wire                   wr_acc = acc && pwrite;
  wire                   trig   = soft_start_q || (start_pin && !pin_q);

  // fifo between host sample writes and the channel shifters
  wire        f_in_ready;
  wire        f_out_valid;
  wire [31:0] f_out_data;
  wire        f_in_valid = wr_acc && (paddr == `DCS_OFS_SAMPLE) && f_in_ready;
  reg  [3:0]  take;
  reg  [1:0]  rr_q;
  wire        f_take = |take;
  wire [3:0]  shift_idle;

  dcs_fifo #(.WIDTH(`DCS_WORD_BITS), .DEPTH(`DCS_FIFO_DEPTH), .AW(`DCS_FIFO_AW)) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (pwdata),
    .out_valid (f_out_valid),
    .out_ready (f_take),
    .out_data  (f_out_data)
  );

  // apb register access
  integer i;
  wire [3:0] idx = paddr[5:2];
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      prdata       <= 32'h00000000;
      div_q        <= `DCS_RST_DIV;
      fend_q       <= 1'b0;
      soft_start_q <= 1'b0;
      pin_q        <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        hold_cfg_q[i] <= `DCS_RST_HOLD;
        phase_q[i]    <= 16'h0000;
      end
    end else if (clk_en) begin
      pin_q        <= start_pin;
      soft_start_q <= 1'b0;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      if (acc) begin
        pready <= 1'b1;
        prdata <= 32'h00000000;
        if (paddr == `DCS_OFS_CTRL) begin
          if (pwrite) soft_start_q <= pwdata[0];
        end else if (paddr == `DCS_OFS_STATUS) begin
          prdata <= {24'h000000, 3'b000, f_in_ready, chan_running};
        end else if (paddr == `DCS_OFS_MODE2) begin
          if (pwrite) div_q <= pwdata[`DCS_DIV_LSB+`DCS_DIV_W-1:`DCS_DIV_LSB];
          prdata <= {27'h0000000, div_q};
        end else if (paddr == `DCS_OFS_SETUP) begin
          if (pwrite) fend_q <= pwdata[`DCS_FEND_BIT];
          prdata <= {26'h0000000, fend_q, 5'h00};
        end else if (paddr[11:4] == 8'h02) begin
          if (pwrite) hold_cfg_q[idx[1:0]] <= pwdata[15:0];
          prdata <= {16'h0000, hold_cfg_q[idx[1:0]]};
        end else if (paddr[11:4] == 8'h03) begin
          if (pwrite) phase_q[idx[1:0]] <= pwdata[15:0];
          prdata <= {16'h0000, phase_q[idx[1:0]]};
        end else if (paddr == `DCS_OFS_SAMPLE) begin
          pslverr <= !pwrite || !f_in_ready;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // fifo words go round robin to each channel in turn, waiting until that channel is idle and running
  always @* begin
    take = 4'b0000;
    if (f_out_valid && chan_running[rr_q] && shift_idle[rr_q]) begin
      take[rr_q] = 1'b1;
    end
  end
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rr_q <= 2'b00;
    end else if (clk_en && f_take) begin
      rr_q <= rr_q + 2'b01;
    end
  end

  // per-channel hold-off, divider and shifter
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gch
      reg [2:0]  st_q;
      reg [15:0] hold_q;
      reg [4:0]  dcnt_q;
      reg [5:0]  bits_q;
      reg [31:0] sh_q;
      wire       tick = (dcnt_q == div_q);
      // idle only after the last bit's rising edge and off a toggle, so a new word
      // always starts with a falling edge carrying its first bit
      assign shift_idle[g] = (bits_q == 6'd0) && serial_clk[g] && !tick;
      always @(posedge core_clk or posedge rst) begin
        if (rst) begin
          st_q                <= ST_IDLE;
          hold_q              <= 16'h0000;
          dcnt_q              <= 5'h00;
          bits_q              <= 6'd0;
          sh_q                <= 32'h00000000;
          serial_clk[g]       <= 1'b0;
          serial_data[g]      <= 1'b0;
          frame_output_pin[g] <= 1'b0;
          chan_running[g]     <= 1'b0;
        end else if (clk_en) begin
          frame_output_pin[g] <= 1'b0;
          if (trig) begin
            st_q            <= ST_HOLD;
            hold_q          <= hold_cfg_q[g];
            chan_running[g] <= 1'b0;
          end else begin
            case (st_q)
              ST_IDLE: st_q <= ST_IDLE;
              ST_HOLD: begin
                if (hold_q == 16'h0000) begin
                  st_q            <= ST_RUN;
                  chan_running[g] <= 1'b1;
                end else begin
                  hold_q <= hold_q - 16'h0001;
                end
              end
              ST_RUN:  st_q <= ST_RUN;
              default: st_q <= ST_IDLE;
            endcase
          end
          // serial bit clock: half period of div+1 core clocks per phase
          dcnt_q <= tick ? 5'h00 : dcnt_q + 5'h01;
          if (tick && st_q == ST_RUN) begin
            serial_clk[g] <= ~serial_clk[g];
            if (serial_clk[g] && bits_q != 6'd0) begin
              serial_data[g] <= sh_q[31];
              sh_q           <= {sh_q[30:0], 1'b0};
              bits_q         <= bits_q - 6'd1;
              if (bits_q == 6'd1 && fend_q) frame_output_pin[g] <= 1'b1;
            end
          end
          if (take[g]) begin
            sh_q   <= f_out_data;
            bits_q <= 6'd32;
            if (!fend_q) frame_output_pin[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate
endmodule // dcs_top

// file: test/dcs_monitor.sv
// port assertions for dcs_top
// assumes: bound into dcs_top, single core_clk domain
`timescale 1ns/1ps
module dcs_monitor (
  // clock and reset
  input wire        core_clk,
  input wire        rst,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  // start and channels
  input wire        start_pin,
  input wire [3:0]  serial_clk,
  input wire [3:0]  frame_output_pin,
  input wire [3:0]  chan_running
);
  reg  [4:0] div_q;
  reg        trig_q;
  reg        sck_q;
  reg  [5:0] cnt_q;
  reg  [1:0] edg_q;
  wire       wr = psel & penable & pready & pwrite;
  wire       tog = serial_clk[0] != sck_q;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_q <= 5'h00;
      trig_q <= 1'b0;
      sck_q <= 1'b0;
      cnt_q <= 6'h00;
      edg_q <= 2'h0;
    end else begin
      sck_q <= serial_clk[0];
      cnt_q <= tog ? 6'h00 : cnt_q + 6'h01;
      if (tog && edg_q != 2'h3)
        edg_q <= edg_q + 2'h1;
      if (wr && paddr == 12'h010)
        div_q <= pwdata[4:0];
      if ($rose(start_pin) || (wr && paddr == 12'h000 && pwdata[0]))
        trig_q <= 1'b1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  apb_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no answer");
  ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
  err_qual_a: assert property (pslverr |-> pready) else $error("stray error");
  frame_apart_a: assert property ($onehot0(frame_output_pin)) else $error("frames met");
  frame_run_a: assert property (frame_output_pin[0] |-> chan_running[0]) else $error("frame");
  run_hold_a: assert property ((~chan_running & $past(chan_running)) == 4'h0) else $error("drop");
  run_trig_a: assert property ($rose(chan_running[0]) |-> trig_q) else $error("no trigger");
  run_order_a: assert property (chan_running[3] |-> chan_running[0]) else $error("order");
  sclk_idle_a: assert property (!chan_running[0] |-> !serial_clk[0]) else $error("idle clk");
  sclk_rate_a: assert property (tog && edg_q == 2'h3 |-> cnt_q == {1'b0, div_q})
    else $error("clock rate");
endmodule // dcs_monitor

// file: test/dcs_sink.sv
// serial sink: gathers 32-bit words from the four channel shifters
// assumes: data stable at serial_clk rise, frame pulse before first bit
`timescale 1ns/1ps
module dcs_sink (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // serial lines
  input  wire [3:0]  serial_clk,
  input  wire [3:0]  frame_output_pin,
  input  wire [3:0]  serial_data,
  // captured words
  output reg  [31:0] word,
  output reg         word_valid
);
  reg     [3:0]  sck_q;
  reg     [3:0]  arm_q;
  reg     [31:0] sh_q [0:3];
  reg     [5:0]  n_q [0:3];
  integer        i;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sck_q <= 4'h0;
      arm_q <= 4'h0;
      word_valid <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        n_q[i] <= 6'h00;
    end else begin
      sck_q <= serial_clk;
      word_valid <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        if (frame_output_pin[i]) begin
          n_q[i] <= 6'h00;
          arm_q[i] <= 1'b1;
        end else if (arm_q[i] & serial_clk[i] & ~sck_q[i]) begin
          sh_q[i] <= {sh_q[i][30:0], serial_data[i]};
          n_q[i] <= (n_q[i] == 6'h1F) ? 6'h00 : n_q[i] + 6'h01;
          if (n_q[i] == 6'h1F) begin
            word <= {sh_q[i][30:0], serial_data[i]};
            word_valid <= 1'b1;
            arm_q[i] <= 1'b0;
          end
        end
      end
    end
  end
endmodule // dcs_sink

// file: test/tb_dcs_top.sv
// bench for dcs_top: apb setup, fifo fill, pin start, serial words
// assumes: dcs_top, dcs_sink and dcs_monitor compiled first
`timescale 1ns/1ps
module tb_dcs_top;
  reg         core_clk = 1'b0;
  reg         rst = 1'b1;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h00000000;
  reg         start_pin = 1'b0;
  wire [31:0] prdata, word;
  wire        pready, pslverr, wvld;
  wire [3:0]  sck, fo, sd, run;
  integer     fails = 0, checks = 0, cyc = 0, i;
  reg  [31:0] rd, seed = 32'h2B0D, expq[$];
  reg         err;
  always #4 core_clk = ~core_clk;
  dcs_top dcs_top_inst (.core_clk(core_clk), .rst(rst), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .start_pin(start_pin), .serial_clk(sck),
    .frame_output_pin(fo), .serial_data(sd), .chan_running(run));
  dcs_sink dcs_sink_inst (.core_clk(core_clk), .rst(rst), .serial_clk(sck),
    .frame_output_pin(fo), .serial_data(sd), .word(word), .word_valid(wvld));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("BAD %0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  // starts one edge late so a release never meets a new setup
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1)
        @(posedge core_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task sample;
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      apb(1, 12'h040, seed);
      if (err === 1'b0)
        expq.push_back(seed);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  always @(posedge core_clk)
    if (wvld === 1'b1)
      check(word, expq.size() ? expq.pop_front() : ~word);
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      complete_run;
    end
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    apb(0, 12'h004, 0);
    check(rd, 32'h00000010);
    apb(0, 12'h0FC, 0);
    check({31'h0, err}, 32'h00000001);
    apb(1, 12'h010, 32'hFFFFFFE1);
    apb(0, 12'h010, 0);
    check(rd, 32'h00000001);
    apb(1, 12'h014, 32'h00000000);
    $display("test registers done");
    for (i = 0; i < 4; i = i + 1) begin
      apb(1, 12'h020 + 4 * i, 4 * i + 1);
      apb(1, 12'h030 + 4 * i, 16384 * i);
    end
    apb(0, 12'h028, 0);
    check(rd, 32'h00000009);
    // four fifo entries plus its output register hold five words; the sixth is refused
    for (i = 0; i < 6; i = i + 1)
      sample;
    check({31'h0, err}, 32'h00000001);
    apb(0, 12'h004, 0);
    check(rd, 32'h00000000);
    $display("test fifo fill done");
    start_pin <= 1'b1;
    repeat (30) @(posedge core_clk);
    check({28'h0, run}, 32'h0000000F);
    for (i = 0; i < 4; i = i + 1)
      sample;
    while (expq.size() != 0)
      @(posedge core_clk);
    repeat (300) @(posedge core_clk);
    $display("test serial stream done");
    complete_run;
  end
endmodule // tb_dcs_top
bind dcs_top dcs_monitor dcs_monitor_inst (.core_clk(core_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .start_pin(start_pin), .serial_clk(serial_clk),
  .frame_output_pin(frame_output_pin), .chan_running(chan_running));
